// ---- design/atp_regs.svh ----
`ifndef ATP_REGS_SVH
`define ATP_REGS_SVH

// register byte offsets
`define ATP_CTRL_OFS    8'h00
`define ATP_PICK_OFS    8'h04
`define ATP_OFFS_OFS    8'h08
`define ATP_HYST_OFS    8'h0C
`define ATP_TDLY_OFS    8'h10
`define ATP_RDLY_OFS    8'h14
`define ATP_STAT_OFS    8'h18
`define ATP_PROG_OFS    8'h1C
`define ATP_ISTAT_OFS   8'h20
`define ATP_IMASK_OFS   8'h24

// control fields
`define ATP_F_OPER      2:0
`define ATP_F_MODE      5:4
`define ATP_F_BLK       9:8
`define ATP_OPER_EN     3'h1
`define ATP_OPER_DIS    3'h5
`define ATP_MODE_OVER   2'h1
`define ATP_MODE_UNDER  2'h2

// reset values (values in hundredths)
`define ATP_RST_CTRL    32'h0000_0011
`define ATP_RST_HYST    14'h000A
`define ATP_PCT_FULL    14'h2710

// interrupt bits
`define ATP_IRQ_PICKUP  0
`define ATP_IRQ_TRIP    1

// time base
`define ATP_MS_NS       1000000
`define ATP_CLK_NS      25

`endif

// ---- design/atp_pkg.sv ----
package atp_pkg;

    typedef enum logic [1:0] {
        ATP_BLK_FREEZE,
        ATP_BLK_ALL,
        ATP_BLK_TRIP
    } atp_blk_mode_t;

    typedef enum logic [1:0] {
        ATP_ST_IDLE,
        ATP_ST_TIMING,
        ATP_ST_RESETTING,
        ATP_ST_TRIPPED
    } atp_state_t;

    typedef struct packed {
        logic        pickup;
        logic        trip;
    } atp_out_t;

endpackage : atp_pkg

// ---- design/atp_top.sv ----
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "atp_regs.svh"

module atp_top
    import atp_pkg::*;
#(
    parameter logic [15:0] P_MS_CYCLES = 16'(`ATP_MS_NS / `ATP_CLK_NS)
) (
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // measurement and control inputs
    input  wire logic [31:0] I_ANALOG_INPUT_VALUE,
    input  wire logic        I_BLOCK,
    input  wire logic        I_THRESHOLD_OFFSET_ENABLE,
    // protection outputs
    output logic             O_PICKUP,
    output logic             O_TRIP,
    output logic             O_IRQ
);

    function automatic logic signed [33:0] sx34(input logic [31:0] v);
        sx34 = signed'({{2{v[31]}}, v});
    endfunction : sx34
    // ---------------- pin synchronisers ----------------
    logic [2:0] blk_sy_reg, blk_sy_next;
    logic [2:0] ofs_sy_reg, ofs_sy_next;
    logic       blk_q_reg,  blk_q_next;
    logic       ofs_q_reg,  ofs_q_next;
    always_comb begin
        blk_sy_next = {blk_sy_reg[1:0], I_BLOCK};
        ofs_sy_next = {ofs_sy_reg[1:0], I_THRESHOLD_OFFSET_ENABLE};
        // a change counts only once stages two and three agree
        blk_q_next  = (blk_sy_reg[1] == blk_sy_reg[2]) ? blk_sy_reg[2] : blk_q_reg;
        ofs_q_next  = (ofs_sy_reg[1] == ofs_sy_reg[2]) ? ofs_sy_reg[2] : ofs_q_reg;
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            blk_sy_reg <= 3'h0;
            ofs_sy_reg <= 3'h0;
            blk_q_reg  <= 1'b0;
            ofs_q_reg  <= 1'b0;
        end else begin
            blk_sy_reg <= blk_sy_next;
            ofs_sy_reg <= ofs_sy_next;
            blk_q_reg  <= blk_q_next;
            ofs_q_reg  <= ofs_q_next;
        end
    end
    // ---------------- register file ----------------
    logic [31:0] ctrl_reg,  ctrl_next;
    logic [31:0] pick_reg,  pick_next;
    logic [31:0] offs_reg,  offs_next;
    logic [13:0] hyst_reg,  hyst_next;
    logic [17:0] tdly_reg,  tdly_next;
    logic [15:0] rdly_reg,  rdly_next;
    logic [1:0]  istat_reg, istat_next;
    logic [1:0]  imask_reg, imask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic        irq_reg, irq_next;
    logic        acc, wr, hit;
    logic [1:0]  ev;
    logic [13:0] prog_reg;
    atp_state_t  state_reg;
    atp_out_t    out_reg;
    logic        cmp_reg;
    assign acc = I_PSEL && I_PENABLE && pready_reg;
    assign wr  = acc && I_PWRITE;
    always_comb begin
        ctrl_next    = ctrl_reg;
        pick_next    = pick_reg;
        offs_next    = offs_reg;
        hyst_next    = hyst_reg;
        tdly_next    = tdly_reg;
        rdly_next    = rdly_reg;
        imask_next   = imask_reg;
        istat_next   = istat_reg;
        prdata_next  = prdata_reg;
        hit          = 1'b1;
        // one wait state: pready rises in the second access cycle
        pready_next  = I_PSEL && I_PENABLE && !pready_reg;
        case (I_PADDR)
            `ATP_CTRL_OFS:  prdata_next = ctrl_reg;
            `ATP_PICK_OFS:  prdata_next = pick_reg;
            `ATP_OFFS_OFS:  prdata_next = offs_reg;
            `ATP_HYST_OFS:  prdata_next = {18'h0, hyst_reg};
            `ATP_TDLY_OFS:  prdata_next = {14'h0, tdly_reg};
            `ATP_RDLY_OFS:  prdata_next = {16'h0, rdly_reg};
            `ATP_STAT_OFS:  prdata_next = {27'h0, blk_q_reg, cmp_reg, state_reg == ATP_ST_RESETTING,
                                           out_reg.trip, out_reg.pickup};
            `ATP_PROG_OFS:  prdata_next = {18'h0, prog_reg};
            `ATP_ISTAT_OFS: prdata_next = {30'h0, istat_reg};
            `ATP_IMASK_OFS: prdata_next = {30'h0, imask_reg};
            default: begin
                prdata_next = 32'h0;
                hit         = 1'b0;
            end
        endcase
        pslverr_next = pready_next && !hit;
        if (!pready_next || I_PWRITE) begin
            prdata_next = 32'h0;
        end
        if (wr) begin
            case (I_PADDR)
                `ATP_CTRL_OFS:  ctrl_next  = I_PWDATA;
                `ATP_PICK_OFS:  pick_next  = I_PWDATA;
                `ATP_OFFS_OFS:  offs_next  = I_PWDATA;
                `ATP_HYST_OFS:  hyst_next  = I_PWDATA[13:0];
                `ATP_TDLY_OFS:  tdly_next  = I_PWDATA[17:0];
                `ATP_RDLY_OFS:  rdly_next  = I_PWDATA[15:0];
                `ATP_ISTAT_OFS: istat_next = istat_reg & ~I_PWDATA[1:0];
                `ATP_IMASK_OFS: imask_next = I_PWDATA[1:0];
                default:        ;
            endcase
        end
        // a new event wins over a write-one clear in the same cycle
        istat_next = istat_next | ev;
        irq_next   = |(istat_next & imask_next);
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ctrl_reg    <= `ATP_RST_CTRL;
            pick_reg    <= 32'h0;
            offs_reg    <= 32'h0;
            hyst_reg    <= `ATP_RST_HYST;
            tdly_reg    <= 18'h0;
            rdly_reg    <= 16'h0;
            istat_reg   <= 2'h0;
            imask_reg   <= 2'h0;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            pick_reg    <= pick_next;
            offs_reg    <= offs_next;
            hyst_reg    <= hyst_next;
            tdly_reg    <= tdly_next;
            rdly_reg    <= rdly_next;
            istat_reg   <= istat_next;
            imask_reg   <= imask_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
        end
    end
    // ---------------- comparator and timers ----------------
    logic                en, frz, ball, btrip, tick, under, cmp_next;
    logic signed [33:0]  val, th, hy;
    logic [15:0]         tick_reg, tick_next;
    logic [17:0]         op_reg, op_next;
    logic [15:0]         rs_reg, rs_next;
    logic [13:0]         prog_next;
    logic [31:0]         prod;
    atp_state_t          state_next;
    atp_out_t            out_next;
    assign en    = ctrl_reg[`ATP_F_OPER] == `ATP_OPER_EN;
    assign frz   = blk_q_reg && ctrl_reg[`ATP_F_BLK] == ATP_BLK_FREEZE;
    assign ball  = blk_q_reg && ctrl_reg[`ATP_F_BLK] == ATP_BLK_ALL;
    assign btrip = blk_q_reg && ctrl_reg[`ATP_F_BLK] == ATP_BLK_TRIP;
    assign under = ctrl_reg[`ATP_F_MODE] == `ATP_MODE_UNDER;
    assign val   = sx34(I_ANALOG_INPUT_VALUE);
    assign th    = sx34(pick_reg) + (ofs_q_reg ? sx34(offs_reg) : 34'sh0);
    assign hy    = signed'({20'h0, hyst_reg});
    assign tick  = tick_reg == P_MS_CYCLES - 16'h1;
    assign prod  = {14'h0, op_reg} * 32'd10000;
    always_comb begin
        tick_next  = tick ? 16'h0 : tick_reg + 16'h1;
        state_next = state_reg;
        op_next    = op_reg;
        rs_next    = rs_reg;
        // hysteresis: once set, hold until the input leaves the band
        if (under) begin
            cmp_next = cmp_reg ? !(val > th + hy) : (val < th);
        end else begin
            cmp_next = cmp_reg ? !(val < th - hy) : (val > th);
        end
        if (!en || ball) begin
            cmp_next   = 1'b0;
            state_next = ATP_ST_IDLE;
            op_next    = 18'h0;
            rs_next    = 16'h0;
        end else begin
            case (state_reg)
                ATP_ST_IDLE: begin
                    if (cmp_reg) begin
                        state_next = ATP_ST_TIMING;
                        op_next    = 18'h0;
                    end
                end
                ATP_ST_TIMING: begin
                    if (!cmp_reg) begin
                        state_next = ATP_ST_RESETTING;
                        rs_next    = 16'h0;
                    end else if (frz) begin
                        op_next = op_reg;
                    end else if (op_reg >= tdly_reg) begin
                        state_next = ATP_ST_TRIPPED;
                    end else if (tick) begin
                        op_next = op_reg + 18'h1;
                    end
                end
                ATP_ST_RESETTING: begin
                    if (cmp_reg) begin
                        state_next = ATP_ST_TIMING;
                    end else if (frz) begin
                        rs_next = rs_reg;
                    end else if (rs_reg >= rdly_reg) begin
                        state_next = ATP_ST_IDLE;
                        op_next    = 18'h0;
                    end else if (tick) begin
                        rs_next = rs_reg + 16'h1;
                    end
                end
                ATP_ST_TRIPPED: begin
                    // a frozen trip is not released by blocking
                    if (!cmp_reg && !frz) begin
                        state_next = ATP_ST_IDLE;
                        op_next    = 18'h0;
                    end
                end
                default: state_next = ATP_ST_IDLE;
            endcase
        end
        out_next.pickup = state_next != ATP_ST_IDLE;
        out_next.trip   = state_next == ATP_ST_TRIPPED && !btrip;
        ev[`ATP_IRQ_PICKUP] = out_next.pickup && !out_reg.pickup;
        ev[`ATP_IRQ_TRIP]   = out_next.trip && !out_reg.trip;
        // divider is costly but only progress reads it
        if (tdly_reg == 18'h0) begin
            prog_next = (state_reg == ATP_ST_TRIPPED) ? `ATP_PCT_FULL : 14'h0;
        end else begin
            prog_next = 14'(prod / {14'h0, tdly_reg});
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            tick_reg  <= 16'h0;
            cmp_reg   <= 1'b0;
            state_reg <= ATP_ST_IDLE;
            op_reg    <= 18'h0;
            rs_reg    <= 16'h0;
            out_reg   <= '0;
            prog_reg  <= 14'h0;
        end else begin
            tick_reg  <= tick_next;
            cmp_reg   <= cmp_next;
            state_reg <= state_next;
            op_reg    <= op_next;
            rs_reg    <= rs_next;
            out_reg   <= out_next;
            prog_reg  <= prog_next;
        end
    end
    assign O_PRDATA  = prdata_reg;
    assign O_PREADY  = pready_reg;
    assign O_PSLVERR = pslverr_reg;
    assign O_PICKUP  = out_reg.pickup;
    assign O_TRIP    = out_reg.trip;
    assign O_IRQ     = irq_reg;
    // ---------------- checks ----------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    a_disable_quiet: assert property (!en |=> !O_PICKUP && !O_TRIP && op_reg == 18'h0)
        else $error("outputs active while disabled");
    a_over_pickup: assert property (en && !ball && !under && !cmp_reg && val > th |=> cmp_reg)
        else $error("over comparator missed pickup");
    a_under_pickup: assert property (en && !ball && under && !cmp_reg && val < th |=> cmp_reg)
        else $error("under comparator missed pickup");
    a_hyst_hold: assert property (en && !ball && !under && cmp_reg && val >= th - hy |=> cmp_reg)
        else $error("pickup dropped inside band");
    a_offset_sum: assert property (!ofs_q_reg |-> th == sx34(pick_reg))
        else $error("threshold offset applied while off");
    a_pickup_now: assert property (en && !ball && cmp_reg && state_reg == ATP_ST_IDLE
                                   |=> O_PICKUP ##1 O_PICKUP || !cmp_reg || !en || ball)
        else $error("pickup not raised at once");
    a_trip_delay: assert property (en && !ball && !frz && !btrip && cmp_reg
                                   && state_reg == ATP_ST_TIMING && op_reg >= tdly_reg
                                   |=> O_TRIP)
        else $error("trip late at trip delay");
    a_reset_start: assert property (en && !ball && !cmp_reg && state_reg == ATP_ST_TIMING
                                    |=> state_reg == ATP_ST_RESETTING && $stable(op_reg))
        else $error("reset timer not started");
    a_reset_done: assert property (en && !ball && !frz && !cmp_reg && rs_reg >= rdly_reg
                                   && state_reg == ATP_ST_RESETTING
                                   |=> !O_PICKUP && op_reg == 18'h0)
        else $error("reset delay did not clear");
    a_prog_idle: assert property (state_reg == ATP_ST_IDLE && op_reg == 18'h0
                                  |=> prog_reg == 14'h0)
        else $error("progress not zero when idle");
    a_freeze_hold: assert property (frz && en && cmp_reg && state_reg == ATP_ST_TIMING
                                    |=> $stable(op_reg))
        else $error("frozen timer moved");
    a_block_all: assert property (en && ball |=> !O_PICKUP && !O_TRIP && op_reg == 18'h0)
        else $error("block all left function active");
    a_block_trip: assert property (btrip |=> !O_TRIP)
        else $error("trip driven in block trip mode");
    a_ms_step: assert property (en && !ball && !tick && state_reg == ATP_ST_TIMING && cmp_reg
                                |=> $stable(op_reg))
        else $error("timer moved without tick");
    c_trip: cover property (state_reg == ATP_ST_TIMING ##1 O_TRIP);
    c_reset: cover property (state_reg == ATP_ST_RESETTING ##1 state_reg == ATP_ST_IDLE);
    c_freeze_trip: cover property (frz && O_TRIP);
    c_block_all: cover property (ball && $past(O_PICKUP));

endmodule : atp_top
`default_nettype wire

// ---- sim/atp_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module atp_src_model (
    // clock
    input  wire logic        i_clk,
    // measurement and control lines towards the block
    output logic      [31:0] o_value,
    output logic             o_block,
    output logic             o_ofs_en
);

    initial begin
        o_value  = 32'h0000_0000;
        o_block  = 1'b0;
        o_ofs_en = 1'b0;
    end

    // slow > 0 stands for a relay input that settles some cycles late
    task automatic drive(input logic [31:0] v, input logic b, input logic e, input int slow);
        repeat (slow + 1) @(posedge i_clk);
        o_value  <= v;
        o_block  <= b;
        o_ofs_en <= e;
    endtask : drive

endmodule : atp_src_model

`default_nettype wire

// ---- sim/atp_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atp_regs.svh"
`define ATP_CHK(got, exp) check_val(32'(got), 32'(exp))

module atp_top_tb
    import atp_pkg::*;
;
    logic             clk;
    logic             rst;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             pickup;
    logic             trip;
    logic             irq;
    wire logic [31:0] val;
    wire logic        blk;
    wire logic        ofs_en;
    int               num_errors;
    int               samples_checked;
    logic [31:0]      seed;
    logic [31:0]      r;
    logic             e;
    int               n;
    int               m_th;
    int               m_hy;
    int               m_md;
    int               m_ofs;
    logic             m_cmp;
    logic [31:0]      rst_tab [10] = '{32'h11, 0, 0, 32'hA, 0, 0, 0, 0, 0, 0};
    int               hy_tab [3] = '{95, 89, 95};
    int               un_tab [4] = '{115, 125, 135, 115};

    atp_top #(.P_MS_CYCLES(16'd4)) i_dut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ANALOG_INPUT_VALUE(val),
        .I_BLOCK(blk), .I_THRESHOLD_OFFSET_ENABLE(ofs_en), .O_PICKUP(pickup),
        .O_TRIP(trip), .O_IRQ(irq)
    );

    atp_src_model i_src (.i_clk(clk), .o_value(val), .o_block(blk), .o_ofs_en(ofs_en));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // hysteresis memory: a picked-up comparator holds until the band is left
    function automatic logic cmp_next(int v, int th, int hy, int md, logic prev);
        if (md == 2) return prev ? (v <= th + hy) : (v < th);
        return prev ? (v >= th - hy) : (v > th);
    endfunction : cmp_next

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic err);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready is looked at on the rising edge itself, before it updates
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) num_errors++;
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask : apb_wr

    task automatic apb_rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask : apb_rd

    task automatic setv(input int v, input logic b, input logic en);
        m_cmp = cmp_next(v, m_th + (en ? m_ofs : 0), m_hy, m_md, m_cmp);
        seed  = lfsr(seed);
        i_src.drive(32'(v), b, en, int'(seed[1:0]));
    endtask : setv

    task automatic settle();
        repeat (14) @(negedge clk);
    endtask : settle

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // run is under 1000 cycles; twenty times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rst = 1'b1;
        num_errors = 0;
        samples_checked = 0;
        seed = 32'h967933D5;
        m_cmp = 1'b0;
        m_th = 0;
        m_hy = 10;
        m_md = 1;
        m_ofs = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rst_tab[i]) begin
            apb_rd(8'(i * 4));
            `ATP_CHK(r, rst_tab[i]);
        end
        apb_rd(8'h30);
        `ATP_CHK(r, 32'h0);
        `ATP_CHK(e, 1'b1);
        $display("test registers done");
        apb_wr(`ATP_PICK_OFS, 32'd100);
        m_th = 100;
        apb_wr(`ATP_TDLY_OFS, 32'd3);
        apb_wr(`ATP_IMASK_OFS, 32'h3);
        setv(101 + int'(seed[5:0]), 1'b0, 1'b0);
        for (n = 0; n < 40 && pickup !== 1'b1; n++) @(negedge clk);
        `ATP_CHK(pickup, m_cmp);
        for (n = 0; n < 40 && trip !== 1'b1; n++) @(negedge clk);
        `ATP_CHK(n >= 8 && n <= 15, 1'b1);
        `ATP_CHK(irq, 1'b1);
        apb_rd(`ATP_ISTAT_OFS);
        `ATP_CHK(r, 32'h3);
        apb_wr(`ATP_PROG_OFS, 32'hFFFF_FFFF);
        apb_rd(`ATP_PROG_OFS);
        `ATP_CHK(r, `ATP_PCT_FULL);
        apb_wr(`ATP_ISTAT_OFS, 32'h3);
        apb_rd(`ATP_ISTAT_OFS);
        `ATP_CHK(r, 32'h0);
        `ATP_CHK(irq, 1'b0);
        $display("test over trip done");
        foreach (hy_tab[i]) begin
            setv(hy_tab[i], 1'b0, 1'b0);
            settle();
            `ATP_CHK(pickup, m_cmp);
        end
        $display("test hysteresis done");
        apb_wr(`ATP_OFFS_OFS, 32'd20);
        m_ofs = 20;
        apb_wr(`ATP_CTRL_OFS, 32'h21);
        m_md = 2;
        foreach (un_tab[i]) begin
            setv(un_tab[i], 1'b0, i < 3);
            settle();
            `ATP_CHK(pickup, m_cmp);
        end
        apb_wr(`ATP_CTRL_OFS, 32'h11);
        m_md = 1;
        setv(0, 1'b0, 1'b0);
        settle();
        $display("test under offset done");
        apb_wr(`ATP_TDLY_OFS, 32'd20);
        apb_wr(`ATP_RDLY_OFS, 32'd5);
        setv(101 + int'(seed[4:0]), 1'b0, 1'b0);
        settle();
        `ATP_CHK(pickup, m_cmp);
        setv(0, 1'b0, 1'b0);
        repeat (8) @(negedge clk);
        apb_rd(`ATP_STAT_OFS);
        `ATP_CHK(r, 32'h5);
        repeat (30) @(negedge clk);
        `ATP_CHK({pickup, trip}, 2'b00);
        apb_wr(`ATP_RDLY_OFS, 32'd0);
        apb_wr(`ATP_TDLY_OFS, 32'd4);
        $display("test reset timer done");
        for (int b = 0; b < 3; b++) begin
            apb_wr(`ATP_CTRL_OFS, 32'h11 | 32'(b << 8));
            setv(101, 1'b0, 1'b0);
            repeat (6) @(negedge clk);
            setv(101, 1'b1, 1'b0);
            repeat (40) @(negedge clk);
            `ATP_CHK(trip, 1'b0);
            `ATP_CHK(pickup, b != 1);
            setv(101, 1'b0, 1'b0);
            repeat (40) @(negedge clk);
            `ATP_CHK(trip, 1'b1);
            setv(101, 1'b1, 1'b0);
            repeat (12) @(negedge clk);
            `ATP_CHK(trip, b == 0);
            setv(0, 1'b0, 1'b0);
            settle();
        end
        $display("test blocking done");
        apb_wr(`ATP_CTRL_OFS, 32'h15);
        setv(101, 1'b0, 1'b0);
        repeat (40) @(negedge clk);
        `ATP_CHK({pickup, trip}, 2'b00);
        apb_wr(`ATP_CTRL_OFS, 32'h11);
        settle();
        `ATP_CHK(pickup, m_cmp);
        $display("test disable done");
        print_verdict();
    end

endmodule : atp_top_tb

`default_nettype wire
